//--- led_driver_diagnostic_mode_control.sv
`timescale 1ns/1ps
module led_driver_diagnostic_mode_control
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	input  wire led_diag_pkg::pin_s   pins,
	input  wire led_diag_pkg::sense_s sense,
	output logic                      serial_out,
	output logic      [15:0]          sink_outputs,
	output logic                      reduced_test_current,
	output logic                      shutdown
);
	import led_diag_pkg::*;

	localparam int IN_W = SENSE_W + 4;

	// Stages start at the pins' idle levels, so leaving reset is not taken
	// for an enable rise that would capture reports from stale comparators.
	localparam logic [IN_W-1:0] IN_RST = {PIN_IDLE, 1'b0, {(2*CHANNELS){1'b1}}};

	// Pins and comparators are asynchronous; a bit moves only once the second
	// and third stages agree, which rejects a single-cycle glitch.
	logic [IN_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
	assign filt_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);

	pin_s   pin_f, pin_p;
	sense_s sns_f;
	assign pin_f = filt_q[IN_W-1 -: 4];
	assign pin_p = prev_q[IN_W-1 -: 4];
	assign sns_f = filt_q[SENSE_W-1:0];

	wire clk_rise = pin_f.serial_clk & ~pin_p.serial_clk;
	wire ld_rise  = pin_f.latch_strobe & ~pin_p.latch_strobe;
	wire ld_fall  = ~pin_f.latch_strobe & pin_p.latch_strobe;
	wire oe_rise  = pin_f.output_enable_n & ~pin_p.output_enable_n;
	wire oe_fall  = ~pin_f.output_enable_n & pin_p.output_enable_n;
	wire sin      = pin_f.serial_in;

	logic [31:0] ctrl_q;
	logic [15:0] shift_q, shift_d, display_q, display_d, saved_q;
	logic [15:0] open_rep_q, short_rep_q;
	logic        temp_ok_q, errmode_q, lowcur_arm_q, restore_q;
	logic        reduced_q, shutdown_q, sout_q;
	logic [2:0]  cnt_q;
	logic [15:0] sink_q;
	func_e       func;

	// Entry is gated by a software enable that reset sets, so a stray strobe can start diagnostics until software clears it.
	// entry detect
	wire enter = ld_rise & pin_f.output_enable_n & ctrl_q[ENABLE_BIT];

	assign func = (cnt_q == CNT_RST)    ? F_TEMP  :
	              (cnt_q == CNT_OPEN)   ? F_OPEN  :
	              (cnt_q == CNT_SHORT)  ? F_SHORT :
	              (cnt_q == CNT_LOWCUR) ? F_LOWCUR : F_SHDN;

	logic flag;
	always_comb
	begin
		flag = 1'b1;
		unique case (func)
			F_TEMP:   flag = temp_ok_q;
			F_OPEN:   flag = &open_rep_q;
			F_SHORT:  flag = &short_rep_q;
			F_LOWCUR: flag = 1'b1;
			F_SHDN:   flag = 1'b1;
		endcase
	end

	logic [15:0] report;
	always_comb
	begin
		report = shift_q;
		unique case (func)
			F_TEMP:   report = {{(CHANNELS-1){1'b1}}, temp_ok_q};
			F_OPEN:   report = open_rep_q;
			F_SHORT:  report = short_rep_q;
			F_LOWCUR: report = shift_q;
			F_SHDN:   report = shift_q;
		endcase
	end

	assign shift_d = (ld_fall & errmode_q) ? report :
	                 clk_rise ? {shift_q[14:0], sin} : shift_q;

	assign display_d = ld_rise ? shift_q :
	                   (ld_fall & restore_q) ? saved_q : display_q;

	wire sout_d = errmode_q ? (flag & sin) : shift_q[15];

	wire [15:0] open_cap  = sns_f.open_sense | ~display_q;
	wire [15:0] short_cap = sns_f.short_sense | ~display_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_q <= IN_RST;
			s2_q <= IN_RST;
			s3_q <= IN_RST;
		end
		else
		begin
			s1_q <= {pins, sense};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			filt_q <= IN_RST;
			prev_q <= IN_RST;
		end
		else
		begin
			filt_q <= filt_d;
			prev_q <= filt_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			shift_q <= WORD_RST;
		else
			shift_q <= shift_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			display_q <= WORD_RST;
		else
			display_q <= display_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sout_q <= 1'b0;
		else
			sout_q <= sout_d;
	end

	// Shutdown darkens the sinks whatever the display holds.
	// sink drive
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sink_q <= WORD_RST;
		else
			sink_q <= (pin_f.output_enable_n | shutdown_q) ? WORD_RST : display_q;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			errmode_q <= 1'b0;
		else if (enter)
			errmode_q <= 1'b1;
		else if (ld_fall)
			errmode_q <= 1'b0;
	end

	// Extra pulses stay at shutdown, they never wrap back to temperature.
	// saturating count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_q <= CNT_RST;
		else if (enter)
			cnt_q <= CNT_RST;
		else if (errmode_q & clk_rise & ~ld_fall & (cnt_q != CNT_SHDN))
			cnt_q <= cnt_q + CNT_OPEN;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			shutdown_q <= 1'b0;
		else if (errmode_q & clk_rise & (cnt_q == CNT_LOWCUR))
			shutdown_q <= ~sin;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			open_rep_q  <= REPORT_RST;
			short_rep_q <= REPORT_RST;
			temp_ok_q   <= 1'b1;
		end
		else if (oe_rise)
		begin
			open_rep_q  <= open_cap;
			short_rep_q <= short_cap;
			temp_ok_q   <= ~sns_f.overtemp_sense;
		end
	end

	// The test pattern replaces the display, so the old picture is held
	// aside and put back at the strobe fall after the test.
	// low-current sequence
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lowcur_arm_q <= 1'b0;
			restore_q    <= 1'b0;
			reduced_q    <= 1'b0;
			saved_q      <= WORD_RST;
		end
		else
		begin
			if (ld_fall & errmode_q & (func == F_LOWCUR))
			begin
				lowcur_arm_q <= 1'b1;
				saved_q      <= display_q;
			end
			else if (oe_rise & lowcur_arm_q)
			begin
				lowcur_arm_q <= 1'b0;
				restore_q    <= 1'b1;
			end
			else if (ld_fall & restore_q)
				restore_q <= 1'b0;
			if (oe_fall & lowcur_arm_q)
				reduced_q <= 1'b1;
			else if (oe_rise)
				reduced_q <= 1'b0;
		end
	end

	assign serial_out           = sout_q;
	assign sink_outputs         = sink_q;
	assign reduced_test_current = reduced_q;
	assign shutdown             = shutdown_q;

	// Zero-wait slave: every transfer completes in one data-phase cycle.
	logic       wr_q;
	logic [7:0] wa_q;
	logic [31:0] rd_q;
	wire        take = hsel & htrans[1] & hready;
	wire [7:0]  ofs  = haddr[7:0];
	wire [31:0] status = {24'h0, shutdown_q, reduced_q, lowcur_arm_q,
	                      func == F_SHDN, cnt_q, errmode_q};
	wire        sel_ctrl    = (ofs == CTRL_OFS);
	wire        sel_status  = (ofs == STATUS_OFS);
	wire        sel_display = (ofs == DISPLAY_OFS);
	wire        sel_report  = (ofs == REPORT_OFS);
	wire        sel_shift   = (ofs == SHIFT_OFS);
	wire [31:0] rmux = sel_ctrl    ? ctrl_q :
	                   sel_status  ? (status | {23'h0, flag, 8'h0}) :
	                   sel_display ? {16'h0, display_q} :
	                   sel_report  ? {short_rep_q, open_rep_q} :
	                   sel_shift   ? {15'h0, temp_ok_q, shift_q} : 32'h0;

	// The address phase is remembered so a write lands with its data phase.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q <= 1'b0;
			wa_q <= 8'h0;
		end
		else
		begin
			wr_q <= take & hwrite;
			wa_q <= ofs;
		end
	end

	// Read data is sampled at the address phase and holds until the next read.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_q <= 32'h0;
		else if (take & ~hwrite)
			rd_q <= rmux;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_q <= CTRL_RST;
		else if (wr_q & (wa_q == CTRL_OFS))
			ctrl_q <= {31'h0, hwdata[ENABLE_BIT]};
	end

	assign hrdata    = rd_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

endmodule : led_driver_diagnostic_mode_control

//--- led_diag_pkg.sv
package led_diag_pkg;

	localparam int              CHANNELS     = 16;
	localparam int              SENSE_W      = 2 * CHANNELS + 1;
	localparam logic [7:0]      CTRL_OFS     = 8'h00;
	localparam logic [7:0]      STATUS_OFS   = 8'h04;
	localparam logic [7:0]      DISPLAY_OFS  = 8'h08;
	localparam logic [7:0]      REPORT_OFS   = 8'h0c;
	localparam logic [7:0]      SHIFT_OFS    = 8'h10;
	localparam logic [31:0]     CTRL_RST     = 32'h0000_0001;
	localparam logic [15:0]     WORD_RST     = 16'h0000;
	localparam logic [15:0]     REPORT_RST   = 16'hffff;
	localparam logic [2:0]      CNT_RST      = 3'h0;
	localparam logic [2:0]      CNT_OPEN     = 3'h1;
	localparam logic [2:0]      CNT_SHORT    = 3'h2;
	localparam logic [2:0]      CNT_LOWCUR   = 3'h3;
	localparam logic [2:0]      CNT_SHDN     = 3'h4;
	localparam int              TEMP_BIT     = 0;
	localparam int              ENABLE_BIT   = 0;
	localparam logic [3:0]      PIN_IDLE     = 4'b0101;

	typedef enum logic [4:0]
	{
		F_TEMP   = 5'b00001,
		F_OPEN   = 5'b00010,
		F_SHORT  = 5'b00100,
		F_LOWCUR = 5'b01000,
		F_SHDN   = 5'b10000
	} func_e;

	typedef struct packed
	{
		logic serial_clk;
		logic serial_in;
		logic latch_strobe;
		logic output_enable_n;
	} pin_s;

	typedef struct packed
	{
		logic                overtemp_sense;
		logic [CHANNELS-1:0] open_sense;
		logic [CHANNELS-1:0] short_sense;
	} sense_s;

endpackage : led_diag_pkg

//--- led_diag_props.sv
`timescale 1ns/1ps
module led_diag_props
(
	input wire logic               hclk,
	input wire logic               hresetn,
	input wire logic               hsel,
	input wire logic [31:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic               hready,
	input wire logic [31:0]        hrdata,
	input wire logic               hreadyout,
	input wire logic               hresp,
	input wire led_diag_pkg::pin_s pins,
	input wire logic [15:0]        sink_outputs,
	input wire logic               reduced_test_current,
	input wire logic               shutdown
);
	import led_diag_pkg::*;
	wire rd_take = hsel && htrans[1] && hready && !hwrite;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready");
	a_unmapped_zero: assert property (rd_take && haddr == 32'h0000_0020 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_count_cap: assert property (rd_take && haddr == {24'h0, STATUS_OFS} |=> hrdata[3:1] <= 3'h4)
		else $error("count above four");
	a_sink_dark: assert property (pins.output_enable_n [*8] |-> sink_outputs == 16'h0)
		else $error("sink on while disabled");
	a_shdn_dark: assert property (shutdown [*3] |-> sink_outputs == 16'h0)
		else $error("sink on in shutdown");
	a_lowcur_off: assert property (pins.output_enable_n [*8] |-> !reduced_test_current)
		else $error("reduced current while disabled");
	// Eight cycles of settling after reset keep the pin filters out of these two.
	a_shdn_steady: assert property (($past(hresetn, 8) && !pins.serial_clk) [*8] |-> $stable(shutdown))
		else $error("shutdown moved without clock");
	a_sink_steady: assert property (($past(hresetn, 8) && $stable(pins)) [*8] |-> $stable(sink_outputs))
		else $error("sink moved with quiet pins");
	cover property (rd_take);
	cover property ($rose(shutdown));
	cover property ($fell(shutdown));
	cover property ($rose(reduced_test_current));
endmodule : led_diag_props
bind led_driver_diagnostic_mode_control led_diag_props led_diag_props_i
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .pins(pins), .sink_outputs(sink_outputs),
	.reduced_test_current(reduced_test_current), .shutdown(shutdown)
);

//--- host_model.sv
`timescale 1ns/1ps
module host_model
(
	input  wire logic          hclk,
	output led_diag_pkg::pin_s pins
);
	import led_diag_pkg::*;
	initial pins = 4'b0101;
	// Eight cycles per level leaves margin over the pin filters.
	task automatic wt();
		repeat (8) @(posedge hclk);
	endtask : wt
	task automatic lvl(input logic b, input logic ld, input logic oe);
		pins.serial_in       <= b;
		pins.latch_strobe    <= ld;
		pins.output_enable_n <= oe;
		wt();
	endtask : lvl
	// Data is set after the previous fall.
	task automatic clk(input logic b);
		pins.serial_in  <= b;
		wt();
		pins.serial_clk <= 1'b1;
		wt();
		pins.serial_clk <= 1'b0;
		wt();
	endtask : clk
	// Pattern sent most significant bit first.
	task automatic word(input logic [15:0] w);
		for (int i = 15; i >= 0; i--)
			clk(w[i]);
	endtask : word
endmodule : host_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import led_diag_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hreadyout;
	logic        serial_out;
	logic        shutdown;
	logic        reduced_test_current;
	logic [15:0] sink_outputs;
	pin_s        pins;
	sense_s      sense = {1'b0, 32'hffff_ffff};
	int          error_cnt = 0;
	int          samples_checked = 0;
	always #12.5 hclk = ~hclk;
	host_model host_model_i (.hclk(hclk), .pins(pins));
	led_driver_diagnostic_mode_control led_driver_diagnostic_mode_control_i
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pins(pins), .sense(sense),
		.serial_out(serial_out), .sink_outputs(sink_outputs),
		.reduced_test_current(reduced_test_current), .shutdown(shutdown)
	);
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic rdy();
		for (int k = 0; k < 20; k++)
		begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		error_cnt++;
		stop_test();
	endtask : rdy
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask : ahb
	task automatic diag(input logic [2:0] n, input logic so, input logic [31:0] rep);
		host_model_i.lvl(1'b1, 1'b0, 1'b0);
		host_model_i.lvl(1'b1, 1'b0, 1'b1);
		host_model_i.lvl(1'b1, 1'b1, 1'b1);
		repeat (n) host_model_i.clk(1'b1);
		ahb(1'b0, STATUS_OFS, 32'h0);
		chk({28'h0, rd[3:0]}, {28'h0, n, 1'b1});
		chk({31'h0, serial_out}, {31'h0, so});
		host_model_i.lvl(1'b0, 1'b1, 1'b1);
		chk({31'h0, serial_out}, 32'h0);
		host_model_i.lvl(1'b1, 1'b0, 1'b1);
		ahb(1'b0, SHIFT_OFS, 32'h0);
		chk(rd, rep);
		chk({31'h0, serial_out}, {31'h0, rep[15]});
	endtask : diag
	task automatic shd(input logic b);
		host_model_i.lvl(1'b1, 1'b1, 1'b1);
		repeat (3) host_model_i.clk(1'b1);
		host_model_i.clk(b);
		chk({31'h0, shutdown}, {31'h0, ~b});
		host_model_i.lvl(1'b1, 1'b0, 1'b0);
	endtask : shd
	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (8) @(posedge hclk);
		ahb(1'b1, CTRL_OFS, 32'h1);
		ahb(1'b0, CTRL_OFS, 32'h0);
		chk(rd, 32'h1);
		ahb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		host_model_i.word(16'ha5c3);
		host_model_i.lvl(1'b1, 1'b0, 1'b0);
		host_model_i.lvl(1'b1, 1'b1, 1'b0);
		ahb(1'b0, DISPLAY_OFS, 32'h0);
		chk(rd, 32'h0000_a5c3);
		chk({16'h0, sink_outputs}, 32'h0000_a5c3);
		sense.open_sense <= 16'h00ff;
		diag(3'h1, 1'b0, 32'h0001_5aff);
		sense <= {1'b0, 16'hffff, 16'hff7f};
		diag(3'h2, 1'b0, 32'h0001_ff7f);
		sense <= {1'b0, 32'hffff_ffff};
		diag(3'h0, 1'b1, 32'h0001_ffff);
		sense.overtemp_sense <= 1'b1;
		diag(3'h0, 1'b0, 32'h0000_fffe);
		shd(1'b0);
		chk({16'h0, sink_outputs}, 32'h0);
		host_model_i.lvl(1'b1, 1'b0, 1'b1);
		shd(1'b1);
		chk({16'h0, sink_outputs}, 32'h0000_ffee);
		host_model_i.lvl(1'b1, 1'b0, 1'b1);
		host_model_i.lvl(1'b1, 1'b1, 1'b1);
		repeat (3) host_model_i.clk(1'b1);
		host_model_i.lvl(1'b1, 1'b0, 1'b1);
		ahb(1'b0, STATUS_OFS, 32'h0);
		chk({31'h0, rd[5]}, 32'h1);
		sense <= {1'b0, 16'hfffd, 16'hbfff};
		host_model_i.word(16'hffff);
		host_model_i.lvl(1'b1, 1'b0, 1'b0);
		chk({31'h0, reduced_test_current}, 32'h1);
		host_model_i.lvl(1'b1, 1'b1, 1'b0);
		host_model_i.lvl(1'b1, 1'b1, 1'b1);
		chk({31'h0, reduced_test_current}, 32'h0);
		host_model_i.lvl(1'b1, 1'b0, 1'b1);
		ahb(1'b0, DISPLAY_OFS, 32'h0);
		chk(rd, 32'h0000_feef);
		ahb(1'b0, REPORT_OFS, 32'h0);
		chk(rd, 32'hbfff_fffd);
		stop_test();
	end
endmodule : tb_top
